// ### hdl/mua_pkg.sv
// package: register map, field layout, opcodes and states of the unary alu block
package mua_pkg;

  // apb byte offsets
  localparam logic [11:0] MUA_OFF_CMD = 12'h000;
  localparam logic [11:0] MUA_OFF_ACC = 12'h004;
  localparam logic [11:0] MUA_OFF_FLAGS = 12'h008;
  localparam logic [11:0] MUA_OFF_PC = 12'h00C;
  localparam logic [11:0] MUA_OFF_WDT = 12'h010;
  localparam logic [11:0] MUA_OFF_IRQ_STAT = 12'h014;
  localparam logic [11:0] MUA_OFF_IRQ_MASK = 12'h018;
  localparam logic [11:0] MUA_OFF_MEM = 12'h100;
  localparam logic [11:0] MUA_MEM_SPAN = 12'h100;

  // command register fields
  localparam int MUA_CMD_OP_LSB = 0;
  localparam int MUA_CMD_ADDR_LSB = 8;
  localparam int MUA_CMD_TGT_LSB = 16;
  localparam int MUA_PC_W = 12;

  // flags register bits
  localparam int MUA_FLG_C = 0;
  localparam int MUA_FLG_AC = 1;
  localparam int MUA_FLG_Z = 2;
  localparam int MUA_FLG_PDF = 3;
  localparam int MUA_FLG_TO = 4;
  localparam int MUA_FLG_BUSY = 5;
  localparam int MUA_FLG_HALT = 6;

  // interrupt status and mask bits
  localparam int MUA_IRQ_W = 3;
  localparam int MUA_IRQ_DONE = 0;
  localparam int MUA_IRQ_HALT = 1;
  localparam int MUA_IRQ_WDT = 2;

  // decimal adjust
  localparam logic [3:0] MUA_BCD_MAX = 4'h9;
  localparam logic [7:0] MUA_DAA_LO = 8'h06;
  localparam logic [7:0] MUA_DAA_HI = 8'h60;

  // reset values
  localparam logic [7:0] MUA_ACC_RST = 8'h00;
  localparam logic [MUA_IRQ_W-1:0] MUA_MASK_RST = 3'h0;
  localparam logic [MUA_PC_W-1:0] MUA_PC_RST = 12'h000;

  // watchdog and memory defaults
  localparam int MUA_WDT_PRESCALE = 256;
  localparam int MUA_WDT_W = 8;
  localparam int MUA_MEM_DEPTH = 64;

  typedef enum logic [3:0] {
    MUA_OP_NOP = 4'h0,
    MUA_OP_COMPLEMENT_IN_PLACE = 4'h1,
    MUA_OP_COMPLEMENT_TO_WORKING = 4'h2,
    MUA_OP_DECIMAL_ADJUST = 4'h3,
    MUA_OP_COUNT_DOWN_IN_PLACE = 4'h4,
    MUA_OP_COUNT_DOWN_TO_WORKING = 4'h5,
    MUA_OP_COUNT_UP_IN_PLACE = 4'h6,
    MUA_OP_COUNT_UP_TO_WORKING = 4'h7,
    MUA_OP_POWERDOWN = 4'h8,
    MUA_OP_UNCONDITIONAL_JUMP = 4'h9
  } mua_op_t;

  typedef enum logic [1:0] {
    MUA_ST_IDLE = 2'b00,
    MUA_ST_EXEC = 2'b01,
    MUA_ST_DUMMY = 2'b10
  } mua_state_t;

endpackage

// ### hdl/mua_core.sv
// unary alu, decimal adjust, power-down and jump datapath with apb register access
//
// Chosen here: the APB register port and the register addresses.
`timescale 1ns/100ps
`default_nettype none

// Contract
// [RULE1] complement in place inverts the memory byte, writes it back, updates zero.
// [RULE2] complement to working puts inverted byte in working register, memory unchanged.
// [RULE3] decimal adjust adds 6 to low nibble if above 9 or half carry.
// [RULE4] decimal adjust adds 6 to high nibble if above 9 or carry.
// [RULE5] decimal adjust correction is 00H, 06H, 60H or 66H.
// [RULE6] decimal adjust result goes to the addressed memory byte.
// [RULE7] decimal adjust changes only carry, set on overflow past two digits.
// [RULE8] count down in place subtracts one and writes back, updates zero.
// [RULE9] count down to working loads byte minus one, memory unchanged, zero.
// [RULE10] count up in place adds one and writes back, updates zero.
// [RULE11] count up to working loads byte plus one, memory unchanged, zero.
// [RULE12] power-down halts execution, stops system clock, keeps all contents.
// [RULE13] power-down clears watchdog counter and prescaler.
// [RULE14] power-down sets power-down flag, clears watchdog timeout flag.
// [RULE15] jump loads program counter with the instruction address.
// [RULE16] jump takes two cycles with a dummy cycle while loading.
// [RULE17] zero flag set when 8-bit result is zero, else cleared.
// [RULE18] increment and decrement wrap mod 256, carry and half carry untouched.
module mua_core
  import mua_pkg::*;
#(
  parameter int MEM_DEPTH = MUA_MEM_DEPTH,
  parameter int WDT_PRESCALE = MUA_WDT_PRESCALE,
  parameter int WDT_W = MUA_WDT_W
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // system side
  output logic irq,
  output logic sys_clk_run,
  output logic [MUA_PC_W-1:0] prog_counter
);

  localparam int AW = (MEM_DEPTH > 1) ? $clog2(MEM_DEPTH) : 1;
  localparam int PW = (WDT_PRESCALE > 1) ? $clog2(WDT_PRESCALE) : 1;
  localparam logic [PW-1:0] PRESC_LAST = PW'(WDT_PRESCALE - 1);
  localparam logic [12:0] MEM_END = 13'(MUA_OFF_MEM) + 13'(MEM_DEPTH * 4);

  // elaboration stops on values the datapath cannot serve
  if (MEM_DEPTH < 2 || MEM_DEPTH > 64 || (MEM_DEPTH & (MEM_DEPTH - 1)) != 0) begin
    $error("MEM_DEPTH must be a power of two from 2 to 64");
  end
  if (WDT_PRESCALE < 2 || WDT_W < 1 || WDT_W > 32) begin
    $error("watchdog prescale or width out of range");
  end

  typedef struct packed {
    mua_state_t state;
    mua_op_t op;
    logic [AW-1:0] addr;
    logic [MUA_PC_W-1:0] target;
    logic [MUA_PC_W-1:0] pc;
    logic [7:0] acc;
    logic c;
    logic ac;
    logic z;
    logic powerdown_flag;
    logic to;
    logic halted;
    // system clock run enable, low from power-down until reset
    logic clk_run;
    logic [WDT_W-1:0] wdt_cnt;
    logic [PW-1:0] presc;
    logic [MUA_IRQ_W-1:0] irq_stat;
    logic [MUA_IRQ_W-1:0] irq_mask;
    logic irq;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [MEM_DEPTH-1:0][7:0] mem;
  } mua_regs_t;

  mua_regs_t r_q;
  mua_regs_t r_d;

  // apb phases and decode
  logic setup;
  logic acc_wr;
  logic mem_hit;
  logic [AW-1:0] mem_idx;
  logic reg_hit;
  logic cmd_busy;
  logic busy;

  assign setup = psel & ~penable;
  assign acc_wr = psel & penable & pwrite & r_q.pready & ~r_q.pslverr;
  assign mem_hit = ({1'b0, paddr} >= 13'(MUA_OFF_MEM)) && ({1'b0, paddr} < MEM_END)
                   && (paddr[1:0] == 2'b00);
  assign mem_idx = paddr[AW+1:2];
  assign reg_hit = (paddr == MUA_OFF_CMD) || (paddr == MUA_OFF_ACC)
                   || (paddr == MUA_OFF_FLAGS) || (paddr == MUA_OFF_PC)
                   || (paddr == MUA_OFF_WDT) || (paddr == MUA_OFF_IRQ_STAT)
                   || (paddr == MUA_OFF_IRQ_MASK);
  assign busy = (r_q.state != MUA_ST_IDLE);
  // a new command is refused while one runs or while powered down
  assign cmd_busy = busy | r_q.halted;

  // datapath results
  logic [7:0] operand;
  logic [7:0] inv_res;
  logic [7:0] dec_res;
  logic [7:0] inc_res;
  logic adj_lo;
  logic adj_hi;
  logic [7:0] daa_corr;
  logic [8:0] daa_sum;

  assign operand = r_q.mem[r_q.addr];
  assign inv_res = ~operand;
  assign dec_res = operand - 8'h01; // [RULE18]
  assign inc_res = operand + 8'h01; // [RULE18]
  assign adj_lo = (r_q.acc[3:0] > MUA_BCD_MAX) | r_q.ac; // [RULE3]
  // high nibble judged on the unadjusted value, no carry from the low fix
  assign adj_hi = (r_q.acc[7:4] > MUA_BCD_MAX) | r_q.c; // [RULE4]
  assign daa_corr = (adj_lo ? MUA_DAA_LO : 8'h00) | (adj_hi ? MUA_DAA_HI : 8'h00); // [RULE5]
  assign daa_sum = {1'b0, r_q.acc} + {1'b0, daa_corr};

  // read mux, sampled in the setup phase
  logic [31:0] rd_val;

  always_comb begin
    rd_val = 32'h0000_0000;
    if (mem_hit) begin
      rd_val[7:0] = r_q.mem[mem_idx];
    end else begin
      unique case (paddr)
        MUA_OFF_CMD: begin
          rd_val[MUA_CMD_OP_LSB +: 4] = r_q.op;
          rd_val[MUA_CMD_ADDR_LSB +: AW] = r_q.addr;
          rd_val[MUA_CMD_TGT_LSB +: MUA_PC_W] = r_q.target;
        end
        MUA_OFF_ACC: begin
          rd_val[7:0] = r_q.acc;
        end
        MUA_OFF_FLAGS: begin
          rd_val[MUA_FLG_C] = r_q.c;
          rd_val[MUA_FLG_AC] = r_q.ac;
          rd_val[MUA_FLG_Z] = r_q.z;
          rd_val[MUA_FLG_PDF] = r_q.powerdown_flag;
          rd_val[MUA_FLG_TO] = r_q.to;
          rd_val[MUA_FLG_BUSY] = busy;
          rd_val[MUA_FLG_HALT] = r_q.halted;
        end
        MUA_OFF_PC: begin
          rd_val[MUA_PC_W-1:0] = r_q.pc;
        end
        MUA_OFF_WDT: begin
          rd_val[WDT_W-1:0] = r_q.wdt_cnt;
        end
        MUA_OFF_IRQ_STAT: begin
          rd_val[MUA_IRQ_W-1:0] = r_q.irq_stat;
        end
        MUA_OFF_IRQ_MASK: begin
          rd_val[MUA_IRQ_W-1:0] = r_q.irq_mask;
        end
        default: begin
          rd_val = 32'h0000_0000;
        end
      endcase
    end
  end

  // next state
  always_comb begin
    logic [MUA_IRQ_W-1:0] ev;
    logic [MUA_IRQ_W-1:0] clr;
    logic tick;
    ev = '0;
    clr = '0;
    tick = 1'b0;
    r_d = r_q;

    // apb answer one cycle after setup
    // refused accesses answer with an error and change nothing
    r_d.pready = setup;
    r_d.pslverr = setup & (~(reg_hit | mem_hit) | (pwrite & (paddr == MUA_OFF_CMD) & cmd_busy));
    if (setup & ~pwrite) begin
      r_d.prdata = rd_val;
    end

    // software writes
    if (acc_wr) begin
      if (mem_hit) begin
        r_d.mem[mem_idx] = pwdata[7:0];
      end else begin
        unique case (paddr)
          MUA_OFF_CMD: begin
            r_d.op = mua_op_t'(pwdata[MUA_CMD_OP_LSB +: 4]);
            r_d.addr = pwdata[MUA_CMD_ADDR_LSB +: AW];
            r_d.target = pwdata[MUA_CMD_TGT_LSB +: MUA_PC_W];
            r_d.state = MUA_ST_EXEC;
          end
          MUA_OFF_ACC: begin
            r_d.acc = pwdata[7:0];
          end
          MUA_OFF_FLAGS: begin
            r_d.c = pwdata[MUA_FLG_C];
            r_d.ac = pwdata[MUA_FLG_AC];
            r_d.z = pwdata[MUA_FLG_Z];
          end
          MUA_OFF_IRQ_STAT: begin
            clr = pwdata[MUA_IRQ_W-1:0];
          end
          MUA_OFF_IRQ_MASK: begin
            r_d.irq_mask = pwdata[MUA_IRQ_W-1:0];
          end
          default: begin
            r_d.irq_mask = r_q.irq_mask;
          end
        endcase
      end
    end

    // watchdog prescaler and counter
    // it keeps counting while halted, so a later time-out still shows
    if (r_q.presc == PRESC_LAST) begin
      r_d.presc = '0;
      tick = 1'b1;
    end else begin
      r_d.presc = r_q.presc + PW'(1);
    end
    if (tick) begin
      r_d.wdt_cnt = r_q.wdt_cnt + WDT_W'(1);
      if (&r_q.wdt_cnt) begin
        r_d.to = 1'b1;
        ev[MUA_IRQ_WDT] = 1'b1;
      end
    end

    // instruction execution, wins over software writes in the same cycle
    unique case (r_q.state)
      MUA_ST_IDLE: begin
        r_d.state = r_d.state;
      end
      MUA_ST_EXEC: begin
        r_d.state = MUA_ST_IDLE;
        r_d.pc = r_q.pc + MUA_PC_W'(1);
        ev[MUA_IRQ_DONE] = 1'b1;
        case (r_q.op)
          MUA_OP_COMPLEMENT_IN_PLACE: begin
            r_d.mem[r_q.addr] = inv_res; // [RULE1]
            r_d.z = (inv_res == 8'h00); // [RULE17]
          end
          MUA_OP_COMPLEMENT_TO_WORKING: begin
            r_d.acc = inv_res; // [RULE2]
            r_d.z = (inv_res == 8'h00); // [RULE17]
          end
          MUA_OP_DECIMAL_ADJUST: begin
            r_d.mem[r_q.addr] = daa_sum[7:0]; // [RULE6]
            r_d.c = r_q.c | adj_hi | daa_sum[8]; // [RULE7]
          end
          MUA_OP_COUNT_DOWN_IN_PLACE: begin
            r_d.mem[r_q.addr] = dec_res; // [RULE8]
            r_d.z = (dec_res == 8'h00); // [RULE17]
          end
          MUA_OP_COUNT_DOWN_TO_WORKING: begin
            r_d.acc = dec_res; // [RULE9]
            r_d.z = (dec_res == 8'h00); // [RULE17]
          end
          MUA_OP_COUNT_UP_IN_PLACE: begin
            r_d.mem[r_q.addr] = inc_res; // [RULE10]
            r_d.z = (inc_res == 8'h00); // [RULE17]
          end
          MUA_OP_COUNT_UP_TO_WORKING: begin
            r_d.acc = inc_res; // [RULE11]
            r_d.z = (inc_res == 8'h00); // [RULE17]
          end
          MUA_OP_POWERDOWN: begin
            r_d.halted = 1'b1; // [RULE12]
            r_d.clk_run = 1'b0; // [RULE12]
            r_d.wdt_cnt = '0; // [RULE13]
            r_d.presc = '0; // [RULE13]
            r_d.powerdown_flag = 1'b1; // [RULE14]
            r_d.to = 1'b0; // [RULE14]
            ev[MUA_IRQ_HALT] = 1'b1;
            ev[MUA_IRQ_WDT] = 1'b0;
          end
          MUA_OP_UNCONDITIONAL_JUMP: begin
            r_d.pc = r_q.target; // [RULE15]
            r_d.state = MUA_ST_DUMMY; // [RULE16]
            ev[MUA_IRQ_DONE] = 1'b0;
          end
          default: begin
            // nop and unused codes only advance the program counter and raise the done event
            r_d.acc = r_d.acc;
          end
        endcase
      end
      MUA_ST_DUMMY: begin
        // dummy slot while the new address is fetched
        r_d.state = MUA_ST_IDLE; // [RULE16]
        ev[MUA_IRQ_DONE] = 1'b1;
      end
      default: begin
        r_d.state = MUA_ST_IDLE;
      end
    endcase

    // sticky status, a new event wins over a clear
    r_d.irq_stat = (r_q.irq_stat & ~clr) | ev;
    r_d.irq = |(r_d.irq_stat & r_d.irq_mask);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r_q <= '0;
      r_q.state <= MUA_ST_IDLE;
      r_q.op <= MUA_OP_NOP;
      r_q.acc <= MUA_ACC_RST;
      r_q.pc <= MUA_PC_RST;
      r_q.irq_mask <= MUA_MASK_RST;
      r_q.clk_run <= 1'b1;
    end else begin
      r_q <= r_d;
    end
  end

  assign prdata = r_q.prdata;
  assign pready = r_q.pready;
  assign pslverr = r_q.pslverr;
  assign irq = r_q.irq;
  // system clock stays off once powered down; contents are kept
  assign sys_clk_run = r_q.clk_run; // [RULE12]
  assign prog_counter = r_q.pc;

endmodule

`default_nettype wire

// ### verification/mua_core_asserts.sv
// concurrent checks on the ports of the unary alu core
`timescale 1ns/100ps
`default_nettype none
module mua_core_asserts
  import mua_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb side
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  // system side
  input wire logic sys_clk_run,
  input wire logic [MUA_PC_W-1:0] prog_counter
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  logic go;
  logic cmd_setup;
  assign go = psel && penable && pready && pwrite && paddr == MUA_OFF_CMD && !pslverr;
  assign cmd_setup = psel && !penable && pwrite && paddr == MUA_OFF_CMD;

  a_ready_after_setup: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  a_ready_one_cycle: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  a_jump_load: assert property (
    go && pwdata[3:0] == 4'h9 |=> ##1 prog_counter == $past(pwdata[27:16], 2))
    else $error("jump target not loaded");
  a_jump_dummy: assert property (
    go && pwdata[3:0] == 4'h9 |=> ##2 $stable(prog_counter))
    else $error("counter moved in dummy cycle");
  a_halt_stop: assert property (go && pwdata[3:0] == 4'h8 |=> ##1 !sys_clk_run)
    else $error("clock still runs after power-down");
  a_halt_stays: assert property (
    !sys_clk_run |=> !sys_clk_run && $stable(prog_counter))
    else $error("execution resumed while halted");
  a_halt_refuse: assert property (!sys_clk_run && cmd_setup |=> pslverr)
    else $error("command taken while halted");
  a_unmapped_err: assert property (psel && !penable && paddr inside {[12'h01C:12'h0FF]}
    |=> pslverr)
    else $error("unmapped access not refused");
endmodule
`default_nettype wire

// ### verification/mua_seq_model.sv
// program sequencer stand-in: counts every new fetch address
`timescale 1ns/100ps
`default_nettype none
module mua_seq_model (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // from the core
  input wire logic [11:0] prog_counter,
  // fetch count
  output var int fetches
);
  logic [11:0] last_q;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fetches <= 0;
      last_q <= 12'h000;
    end else if (prog_counter !== last_q) begin
      fetches <= fetches + 1;
      last_q <= prog_counter;
    end
  end
endmodule
`default_nettype wire

// ### verification/mcu_unary_alu_and_jump_ops_tb.sv
// self-checking bench for the unary alu core
`timescale 1ns/100ps
`default_nettype none
module mcu_unary_alu_and_jump_ops_tb;
  import mua_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, sys_clk_run, err;
  logic [11:0] paddr, prog_counter;
  logic [31:0] pwdata, prdata, rd;
  int num_errors, checks, cyc, acc, fl, pc, a, op, v, r, k, f0;
  int m[64];
  int dtab[4] = '{8'h12, 8'h1B, 8'hB2, 8'hAB};

  mua_core #(.WDT_PRESCALE(16), .WDT_W(2)) mua_core_i (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
    .sys_clk_run(sys_clk_run), .prog_counter(prog_counter));
  mua_seq_model mua_seq_model_i (.pclk(pclk), .presetn(presetn),
    .prog_counter(prog_counter), .fetches());

  task automatic summarize;
    if (num_errors == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      num_errors++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask

  // one apb transfer: setup, then access until pready is seen at a rising edge
  task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic cmd(input int o, input int ad, input int t);
    apb(1'b1, MUA_OFF_CMD, 32'((t << 16) | (ad << 8) | o));
    for (int n = 0; n < 10; n++) begin
      apb(1'b0, MUA_OFF_FLAGS, 32'h0);
      if (rd[MUA_FLG_BUSY] === 1'b0) break;
    end
  endtask

  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      num_errors++;
      summarize();
    end
  end

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    v = $urandom(80);
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    for (a = 0; a < 64; a++) begin
      m[a] = (a == 1) ? 255 : (a == 0) ? 0 : $urandom % 256;
      apb(1'b1, MUA_OFF_MEM + 12'(4 * a), 32'(m[a]));
    end
    apb(1'b1, MUA_OFF_IRQ_MASK, 32'h1);
    for (int i = 0; i < 56; i++) begin
      op = 1 + i % 7;
      a = i % 8;
      k = i / 7;
      acc = (op == 3) ? dtab[k % 4] : $urandom % 256;
      fl = (op == 3) ? ((k > 3) ? 3 : 4) : $urandom % 8;
      apb(1'b1, MUA_OFF_ACC, 32'(acc));
      apb(1'b1, MUA_OFF_FLAGS, 32'(fl));
      v = m[a];
      if (op == 3) begin
        r = ((acc % 16) > 9 || fl[1]) ? 6 : 0;
        if (acc / 16 > 9 || fl[0]) r += 96;
        fl[0] = fl[0] | (r > 95) | (acc + r > 255);
        m[a] = (acc + r) % 256;
      end else begin
        r = ((op < 3) ? ~v : (op < 6) ? v - 1 : v + 1) & 255;
        fl[2] = (r == 0);
        if (op == 1 || op == 4 || op == 6) m[a] = r;
        else acc = r;
      end
      pc = (pc + 1) % 4096;
      cmd(op, a, 0);
      apb(1'b0, MUA_OFF_MEM + 12'(4 * a), 32'h0);
      chk(rd, m[a]);
      apb(1'b0, MUA_OFF_ACC, 32'h0);
      chk(rd, acc);
      apb(1'b0, MUA_OFF_FLAGS, 32'h0);
      chk(rd & 32'h7, fl);
      chk(32'(prog_counter), pc);
      chk(32'(irq), 1);
      apb(1'b1, MUA_OFF_IRQ_STAT, 32'h1);
      @(negedge pclk);
      chk(32'(irq), 0);
    end
    // no-operation and unused codes leave memory, working register and flags alone and advance the program counter
    for (int j = 0; j < 2; j++) begin
      cmd((j == 0) ? 0 : 10 + $urandom % 6, 3, 0);
      pc = (pc + 1) % 4096;
      apb(1'b0, MUA_OFF_MEM + 12'h00C, 32'h0);
      chk(rd, m[3]);
      apb(1'b0, MUA_OFF_ACC, 32'h0);
      chk(rd, acc);
      apb(1'b0, MUA_OFF_FLAGS, 32'h0);
      chk(rd & 32'h7, fl);
      chk(32'(prog_counter), pc);
    end
    apb(1'b0, 12'h01C, 32'h0);
    chk(32'(err), 1);
    chk(rd, 0);
    v = $urandom % 4096;
    cmd(9, 0, v);
    pc = v;
    chk(32'(prog_counter), pc);
    apb(1'b1, MUA_OFF_IRQ_MASK, 32'h0);
    apb(1'b0, MUA_OFF_FLAGS, 32'h0);
    chk(32'(rd[MUA_FLG_TO]), 1);
    cmd(8, 0, 0);
    pc = (pc + 1) % 4096;
    apb(1'b0, MUA_OFF_WDT, 32'h0);
    chk(rd, 0);
    apb(1'b0, MUA_OFF_FLAGS, 32'h0);
    chk(rd & 32'h58, 32'h48);
    chk(32'(sys_clk_run), 0);
    chk(32'(irq), 0);
    apb(1'b1, MUA_OFF_IRQ_MASK, 32'h2);
    @(negedge pclk);
    chk(32'(irq), 1);
    f0 = mua_seq_model_i.fetches;
    apb(1'b1, MUA_OFF_CMD, 32'h6);
    chk(32'(err), 1);
    apb(1'b0, MUA_OFF_MEM + 12'h014, 32'h0);
    chk(rd, m[5]);
    chk(32'(prog_counter), pc);
    chk(mua_seq_model_i.fetches, f0);
    // only a reset leaves power-down
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, MUA_OFF_FLAGS, 32'h0);
    chk(rd, 0);
    chk(32'(sys_clk_run), 1);
    chk(32'(prog_counter), 0);
    chk(32'(irq), 0);
    summarize();
  end
endmodule

bind mua_core mua_core_asserts mua_core_asserts_i (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .pready(pready), .pslverr(pslverr), .sys_clk_run(sys_clk_run),
  .prog_counter(prog_counter));
`default_nettype wire
